/* hdl/sbfw_pkg.sv */
// shared constants and types for the serial boot flash write receiver
package sbfw_pkg;

   // ********************************
   // byte values on the serial link
   // ********************************
   localparam logic [7:0] MATCH_A = 8'h86;   // first matching byte, option a
   localparam logic [7:0] MATCH_B = 8'h30;   // first matching byte, option b
   localparam logic [7:0] OP_WRITE = 8'h30;  // flash write operation command
   localparam logic [7:0] RES_OK = 8'h55;    // completion code
   localparam logic [7:0] RES_OVW = 8'haa;   // overwrite detected code

   // ********************************
   // frame and record layout
   // ********************************
   localparam logic [8:0] ADDR_BYTES = 9'h006;   // two 24-bit addresses
   localparam logic [8:0] CNT_ADDR_BYTES = 9'h003;
   localparam logic [8:0] REC_HDR = 9'h004;      // len, addr hi, addr lo, type
   localparam logic [8:0] REC_IDX_AHI = 9'h001;
   localparam logic [8:0] REC_IDX_ALO = 9'h002;
   localparam logic [8:0] REC_IDX_TYPE = 9'h003;
   localparam logic [7:0] REC_TYPE_EOF = 8'h01;  // end-of-file record
   localparam logic [3:0] UART_LAST_BIT = 4'h9;  // start, 8 data, stop

   // ********************************
   // reset values
   // ********************************
   localparam logic [15:0] CKS_RESET = 16'h0000;
   localparam logic [23:0] ADDR_RESET = 24'h000000;

   // ********************************
   // types
   // ********************************
   typedef enum logic [2:0] {
      ST_MATCH,
      ST_CMD,
      ST_ADDR,
      ST_PWD,
      ST_REC,
      ST_RESP,
      ST_DONE
   } sbfw_state_t;

   // one byte headed for flash
   typedef struct packed {
      logic valid;
      logic [23:0] addr;
      logic [7:0] data;
   } sbfw_flash_wr_t;

   // one byte of the password string
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sbfw_byte_t;

endpackage

/* hdl/sbfw_top.sv */
// serial boot flash write command receiver with its own serial port
// What this block does
// - echo correct matching byte and write command byte back to the host
// - all bytes both ways run at the adjusted baud divisor
// - nothing is sent back while address and password bytes arrive
// - completion code is byte n-2, or byte n when no checksum bytes follow; overwrite code is always byte n
// - on success send checksum high byte, then checksum low byte
// - after an error seen before the result code goes out no checksum bytes are sent
module sbfw_top
   import sbfw_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic [15:0] baud_div_in,
   input wire logic rxd_in,
   input wire logic [7:0] pwd_len_in,
   input wire logic overwrite_in,
   output logic txd_out,
   output logic [23:0] pwd_cnt_addr_out,
   output logic [23:0] pwd_cmp_addr_out,
   output sbfw_byte_t pwd_byte_out,
   output sbfw_flash_wr_t flash_wr_out,
   output logic done_out,
   output logic error_out
);

   // ********************************
   // state record
   // ********************************
   typedef struct packed {
      sbfw_state_t state;
      logic rx_busy;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_vld;
      logic [7:0] rx_byte;
      logic tx_busy;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [9:0] tx_sh;
      logic txd;
      logic [1:0] resp_idx;
      logic [8:0] idx;
      logic [7:0] rec_len;
      logic [7:0] rec_type;
      logic [15:0] rec_addr;
      logic [23:0] cnt_addr;
      logic [23:0] cmp_addr;
      logic [15:0] cks;
      logic ovw;
      logic ferr;
      logic err;
      sbfw_byte_t pwd;
      sbfw_flash_wr_t wr;
      logic done;
   } sbfw_regs_t;

   sbfw_regs_t q;
   sbfw_regs_t d;
   logic [15:0] bit_len;
   logic [7:0] b;
   logic [8:0] rec_end;

   // bit counter reload, one less than the bit time in clocks, guarded so a zero divisor cannot stall
   assign bit_len = (baud_div_in < 16'h0002) ? 16'h0001 :
      baud_div_in - 16'h0001;
   assign b = q.rx_byte;
   assign rec_end = {1'b0, q.rec_len} + REC_HDR;

   // ********************************
   // next state
   // ********************************
   always_comb begin
      d = q;
      d.rx_vld = 1'b0;
      d.pwd.valid = 1'b0;
      d.wr.valid = 1'b0;

      if (!q.rx_busy) begin
         if (!rxd_in) begin
            d.rx_busy = 1'b1;
            // detect edge already spent one clock, so half a bit minus one
            d.rx_cnt = {1'b0, baud_div_in[15:1]} - 16'h0001;  // mid-bit
            d.rx_bit = 4'h0;
         end
      end else if (q.rx_cnt != 16'h0000) begin
         d.rx_cnt = q.rx_cnt - 16'h0001;
      end else begin
         d.rx_cnt = bit_len;
         d.rx_bit = q.rx_bit + 4'h1;
         if (q.rx_bit == 4'h0) begin
            // a start bit that went high again was a glitch
            if (rxd_in) begin
               d.rx_busy = 1'b0;
            end
         end else if (q.rx_bit == UART_LAST_BIT) begin
            d.rx_busy = 1'b0;
            if (rxd_in) begin
               d.rx_vld = 1'b1;
               d.rx_byte = q.rx_sh;
            end else begin
               d.ferr = 1'b1;  // bad stop bit, byte dropped
            end
         end else begin
            d.rx_sh = {rxd_in, q.rx_sh[7:1]};
         end
      end

      if (q.tx_busy) begin
         if (q.tx_cnt != 16'h0000) begin
            d.tx_cnt = q.tx_cnt - 16'h0001;
         end else begin
            d.tx_cnt = bit_len;
            if (q.tx_bit == UART_LAST_BIT) begin
               d.tx_busy = 1'b0;
               d.txd = 1'b1;
            end else begin
               d.tx_sh = {1'b1, q.tx_sh[9:1]};
               d.txd = q.tx_sh[1];
               d.tx_bit = q.tx_bit + 4'h1;
            end
         end
      end

      // overwrite is sticky, a new report always wins
      if (overwrite_in) begin
         d.ovw = 1'b1;
      end

      // error flag kept in a flop so the port has no gate in front
      d.err = d.ovw | d.ferr;

      // command sequence, one step per received byte, then one step per reply byte sent
      unique case (q.state)
         ST_MATCH: begin
            if (q.rx_vld && (b == MATCH_A || b == MATCH_B)) begin
               d.state = ST_CMD;
               d.tx_busy = 1'b1;
               d.tx_sh = {1'b1, b, 1'b0};
               d.txd = 1'b0;
               d.tx_bit = 4'h0;
               d.tx_cnt = bit_len;
            end
         end
         ST_CMD: begin
            if (q.rx_vld) begin
               // only the write command moves on
               if (b == OP_WRITE) begin
                  d.state = ST_ADDR;
                  d.idx = 9'h000;
                  d.tx_busy = 1'b1;
                  d.tx_sh = {1'b1, b, 1'b0};
                  d.txd = 1'b0;
                  d.tx_bit = 4'h0;
                  d.tx_cnt = bit_len;
               end else begin
                  d.state = ST_MATCH;
               end
            end
         end
         ST_ADDR: begin
            if (q.rx_vld) begin
               d.idx = q.idx + 9'h001;
               if (q.idx < CNT_ADDR_BYTES) begin
                  d.cnt_addr = {q.cnt_addr[15:0], b};
               end else begin
                  d.cmp_addr = {q.cmp_addr[15:0], b};
               end
               if (q.idx == ADDR_BYTES - 9'h001) begin
                  d.idx = 9'h000;
                  d.state = (pwd_len_in == 8'h00) ? ST_REC : ST_PWD;
               end
            end
         end
         ST_PWD: begin
            // password bytes passed on, no reply
            if (q.rx_vld) begin
               d.pwd.valid = 1'b1;
               d.pwd.data = b;
               d.idx = q.idx + 9'h001;
               if (q.idx[7:0] == pwd_len_in - 8'h01) begin
                  d.idx = 9'h000;
                  d.state = ST_REC;
               end
            end
         end
         ST_REC: begin
            if (q.rx_vld) begin
               d.idx = q.idx + 9'h001;
               if (q.idx == 9'h000) begin
                  d.rec_len = b;
               end else if (q.idx == REC_IDX_AHI) begin
                  d.rec_addr[15:8] = b;
               end else if (q.idx == REC_IDX_ALO) begin
                  d.rec_addr[7:0] = b;
               end else if (q.idx == REC_IDX_TYPE) begin
                  d.rec_type = b;
               end else if (q.idx < rec_end) begin
                  d.wr.valid = 1'b1;
                  d.wr.addr = {8'h00, q.rec_addr};
                  d.wr.data = b;
                  d.rec_addr = q.rec_addr + 16'h0001;
                  d.cks = q.cks + {8'h00, b};
               end else begin
                  // record checksum byte closes the record
                  d.idx = 9'h000;
                  if (q.rec_type == REC_TYPE_EOF) begin
                     d.state = ST_RESP;
                     d.resp_idx = 2'h0;
                  end
               end
            end
         end
         ST_RESP: begin
            if (!q.tx_busy) begin
               d.tx_busy = 1'b1;
               d.txd = 1'b0;
               d.tx_bit = 4'h0;
               d.tx_cnt = bit_len;
               d.resp_idx = q.resp_idx + 2'h1;
               if (q.resp_idx == 2'h0) begin
                  d.tx_sh = {1'b1, (q.ovw ? RES_OVW : RES_OK), 1'b0};
                  if (q.ovw || q.ferr) begin
                     d.state = ST_DONE;
                  end
               end else if (q.resp_idx == 2'h1) begin
                  d.tx_sh = {1'b1, q.cks[15:8], 1'b0};
               end else begin
                  d.tx_sh = {1'b1, q.cks[7:0], 1'b0};
                  d.state = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            // session over; only a reset starts another
            d.done = ~q.tx_busy;
         end
         default: begin
            d.state = ST_MATCH;
         end
      endcase
   end

   // ********************************
   // registers
   // ********************************
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         q <= '0;
         q.state <= ST_MATCH;
         q.txd <= 1'b1;  // line idles high
         q.cks <= CKS_RESET;
         q.cnt_addr <= ADDR_RESET;
         q.cmp_addr <= ADDR_RESET;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state record
   assign txd_out = q.txd;
   assign pwd_cnt_addr_out = q.cnt_addr;
   assign pwd_cmp_addr_out = q.cmp_addr;
   assign pwd_byte_out = q.pwd;
   assign flash_wr_out = q.wr;
   assign done_out = q.done;
   assign error_out = q.err;

endmodule

/* testbench/sbfw_host_model.sv */
// host programmer model: byte sender and reply catcher on the serial link
module sbfw_host_model (
   input wire logic mclk_in,
   input wire logic [15:0] baud_div_in,
   input wire logic txd_in,
   output logic rxd_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // serial link behaviour
   // ****************************************
   logic [7:0] rx_q[$];

   // idle line is high between frames
   initial rxd_out = 1'b1;

   task automatic send_byte(input logic [7:0] b, input logic stop = 1'b1);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      @(posedge mclk_in);
      #1;
      for (int i = 0; i < 10; i++) begin
         rxd_out = f[i];
         repeat (baud_div_in) @(posedge mclk_in);
         #1;
      end
      // a low stop bit must not leave the line low
      rxd_out = 1'b1;
   endtask

   // reply bytes sampled mid-bit, lsb first
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge txd_in);
         repeat (baud_div_in / 2) @(posedge mclk_in);
         for (int i = 0; i < 8; i++) begin
            repeat (baud_div_in) @(posedge mclk_in);
            b[i] = txd_in;
         end
         repeat (baud_div_in) @(posedge mclk_in);
         rx_q.push_back(b);
      end
   end
endmodule

/* testbench/sbfw_top_assertions.sv */
// port-level checks for the serial boot flash write receiver
module sbfw_top_assertions
   import sbfw_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic [15:0] baud_div_in,
   input wire logic txd_out,
   input wire logic done_out,
   input wire logic error_out,
   input wire sbfw_byte_t pwd_byte_out,
   input wire sbfw_flash_wr_t flash_wr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   // ****************************************
   // helpers and properties
   // ****************************************
   logic [15:0] low_q;

   // low run length, so whole bit times can be seen
   always_ff @(posedge mclk_in) begin
      if (reset_in || txd_out)
         low_q <= 16'h0000;
      else
         low_q <= low_q + 16'h0001;
   end

   sequence s_idle8;
      txd_out [*8];
   endsequence

   bit_time_a: assert property (
      $rose(txd_out) |-> (low_q % baud_div_in) == 16'h0000)
      else $error("reply low run is not whole bit times");
   quiet_pwd_a: assert property (
      pwd_byte_out.valid |-> s_idle8)
      else $error("reply line active during password");
   quiet_data_a: assert property (
      flash_wr_out.valid |-> s_idle8)
      else $error("reply line active during record data");
   wr_pulse_a: assert property (
      flash_wr_out.valid |=> !flash_wr_out.valid)
      else $error("flash write valid longer than one cycle");
   pwd_pulse_a: assert property (
      pwd_byte_out.valid |=> !pwd_byte_out.valid)
      else $error("password valid longer than one cycle");
   done_idle_a: assert property (
      $rose(done_out) |-> s_idle8)
      else $error("reply line busy after reply finished");
   done_hold_a: assert property (
      done_out |=> done_out && !flash_wr_out.valid)
      else $error("done dropped or data after reply");
   err_hold_a: assert property (
      error_out |=> error_out)
      else $error("error flag dropped before reset");
endmodule

bind sbfw_top sbfw_top_assertions u_sbfw_top_assertions (
   .mclk_in(mclk_in), .reset_in(reset_in), .baud_div_in(baud_div_in),
   .txd_out(txd_out), .done_out(done_out), .error_out(error_out),
   .pwd_byte_out(pwd_byte_out), .flash_wr_out(flash_wr_out));

/* testbench/sbfw_top_tb.sv */
// self-checking bench for the serial boot flash write receiver
module sbfw_top_tb
   import sbfw_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // stimulus and checking
   // ****************************************
   localparam logic [15:0] DIV = 16'h0004;
   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   logic overwrite_in = 1'b0;
   logic [7:0] pwd_len_in = 8'h00;
   logic rxd_in, txd_out, done_out, error_out;
   logic [23:0] pwd_cnt_addr_out, pwd_cmp_addr_out;
   sbfw_byte_t pwd_byte_out;
   sbfw_flash_wr_t flash_wr_out;
   int miscompares = 0;
   int tests_run = 0;
   int n_pwd = 0;
   logic [31:0] wr_q[$];
   logic [7:0] pwd_q[$];

   sbfw_top u_sbfw_top (.mclk_in(mclk_in), .reset_in(reset_in),
      .baud_div_in(DIV), .rxd_in(rxd_in), .pwd_len_in(pwd_len_in),
      .overwrite_in(overwrite_in), .txd_out(txd_out),
      .pwd_cnt_addr_out(pwd_cnt_addr_out),
      .pwd_cmp_addr_out(pwd_cmp_addr_out), .pwd_byte_out(pwd_byte_out),
      .flash_wr_out(flash_wr_out), .done_out(done_out),
      .error_out(error_out));
   sbfw_host_model u_sbfw_host_model (.mclk_in(mclk_in),
      .baud_div_in(DIV), .txd_in(txd_out), .rxd_out(rxd_in));

   always #12.5 mclk_in = ~mclk_in;

   // collect password pulses and flash writes
   always @(posedge mclk_in) begin
      if (pwd_byte_out.valid === 1'b1) begin
         n_pwd++;
         pwd_q.push_back(pwd_byte_out.data);
      end
      if (flash_wr_out.valid === 1'b1)
         wr_q.push_back({flash_wr_out.addr, flash_wr_out.data});
   end

   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // bounded wait for one reply byte
   task automatic expect_rx(input string what, input logic [7:0] exp);
      int n;
      n = 0;
      while (u_sbfw_host_model.rx_q.size() == 0 && n < 200) begin
         @(posedge mclk_in);
         n++;
      end
      check(what, {24'h0, exp}, n < 200 ?
         {24'h0, u_sbfw_host_model.rx_q.pop_front()} : 32'hffffffff);
   endtask

   // long enough for a whole reply frame to show up
   task automatic quiet(input string what);
      repeat (60) @(posedge mclk_in);
      check(what, 32'h0, u_sbfw_host_model.rx_q.size());
   endtask

   task automatic send_all(input logic [7:0] q[$]);
      foreach (q[i])
         u_sbfw_host_model.send_byte(q[i]);
   endtask

   task automatic t_refuse();
      u_sbfw_host_model.send_byte(8'h11);
      quiet("bad match byte");
      u_sbfw_host_model.send_byte(MATCH_A);
      expect_rx("match echo", MATCH_A);
      u_sbfw_host_model.send_byte(8'h31);
      quiet("bad command byte");
      u_sbfw_host_model.send_byte(MATCH_B);
      expect_rx("rematch echo", MATCH_B);
   endtask

   task automatic t_session(input logic [7:0] m, input logic [7:0] plen,
      input logic ovw, input logic bad);
      logic [7:0] seq[$];
      @(posedge mclk_in);
      #1;
      reset_in = 1'b1;
      pwd_len_in = plen;
      repeat (2) @(posedge mclk_in);
      #1;
      reset_in = 1'b0;
      n_pwd = 0;
      wr_q.delete();
      pwd_q.delete();
      u_sbfw_host_model.send_byte(m);
      expect_rx("match echo", m);
      u_sbfw_host_model.send_byte(OP_WRITE);
      expect_rx("command echo", OP_WRITE);
      seq = {8'h12, 8'h34, 8'h56, 8'hab, 8'hcd, 8'hef};
      for (int i = 0; i < plen; i++)
         seq.push_back(8'h5a + 8'(i));
      seq = {seq, 8'h02, 8'h01, 8'h00, 8'h00, 8'ha1, 8'hb2, 8'h5a};
      send_all(seq);
      // overwrite report comes from the flash side after the data
      @(posedge mclk_in);
      #1;
      overwrite_in = ovw;
      @(posedge mclk_in);
      #1;
      overwrite_in = 1'b0;
      // a frame with a low stop bit is dropped and flags an error
      if (bad) begin
         u_sbfw_host_model.send_byte(8'h00, 1'b0);
         repeat (8) @(posedge mclk_in);
         #1;
      end
      send_all({8'h00, 8'h00, 8'h00, REC_TYPE_EOF, 8'hff});
      expect_rx("result code", ovw ? RES_OVW : RES_OK);
      if (!ovw && !bad)
         expect_rx("checksum high", 8'h01);
      if (!ovw && !bad)
         expect_rx("checksum low", 8'h53);
      quiet("after reply");
      check("count address", 32'h123456, pwd_cnt_addr_out);
      check("compare address", 32'habcdef, pwd_cmp_addr_out);
      check("password bytes", 32'(plen), n_pwd);
      if (plen != 8'h00)
         check("password first", 32'h5a, pwd_q[0]);
      if (plen != 8'h00)
         check("password last", 32'(8'h5a + plen - 8'h01),
            pwd_q[plen - 8'h01]);
      check("write 0", 32'h000100a1, wr_q[0]);
      check("write 1", 32'h000101b2, wr_q[1]);
      check("done", 32'h1, done_out);
      check("error", 32'(ovw | bad), error_out);
   endtask

   task automatic summarize();
      $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // watchdog, far beyond the few thousand cycles the run needs
   initial begin
      #500us;
      miscompares++;
      summarize();
   end

   initial begin
      repeat (12) @(posedge mclk_in);
      #1;
      reset_in = 1'b0;
      t_refuse();
      t_session(MATCH_A, 8'h02, 1'b0, 1'b0);
      t_session(MATCH_B, 8'h00, 1'b1, 1'b0);
      t_session(MATCH_A, 8'h01, 1'b0, 1'b1);
      summarize();
   end
endmodule
